// ---- uhc_host_ctrl.sv ----
// usb host state machine, attach detection, pipe selection and bus commands
//
// Our own choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
module uhc_host_ctrl #(
   parameter int NPIPE = 7,
   parameter int PNW = 3,
   parameter int BUS_RESET_NS = uhc_pkg::BUS_RESET_NS
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire uhc_pkg::uhc_avm_req_t avs_req,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire uhc_pkg::uhc_line_t line_i,
   output logic vbus_en_o,
   output logic bus_reset_o,
   output logic resume_o,
   output logic sof_active_o,
   output logic host_irq_o,
   output logic [6:0] dev_addr_o,
   output logic [PNW-1:0] flow_pipe_o,
   output logic flow_run_o,
   output logic [NPIPE-1:0] pipe_ready_o
);
   localparam int RESET_CYC = (BUS_RESET_NS + uhc_pkg::CLK_PERIOD_NS - 1)
      / uhc_pkg::CLK_PERIOD_NS;
   localparam logic [23:0] RESET_LAST = 24'(RESET_CYC - 1);

   uhc_pkg::uhc_hstate_t state_r;
   uhc_pkg::uhc_hstate_t state_nxt;
   logic usb_en_r;
   logic host_sel_r;
   logic detach_r;
   logic sof_en_r;
   logic resume_r;
   logic vbus_r;
   logic rst_busy_r;
   logic [23:0] rst_cnt_r;
   logic rst_done;
   logic rst_sent_r;
   logic wakeup_r;
   logic up_rsm_r;
   logic rst_ien_r;
   logic wake_ien_r;
   logic rsm_ien_r;
   logic owner_r;
   logic flow_rdy_r;
   logic [PNW-1:0] cpu_pipe_r;
   logic [PNW-1:0] flow_pipe_r;
   logic [6:0] taddr_r;
   uhc_pkg::uhc_pipe_cfg_t pipe_r [NPIPE];
   logic connected;
   logic wr_ack;
   logic rst_line;
   logic [31:0] wd;
   logic [3:0] be;
   logic [7:0] adr;
   logic [PNW-1:0] sel_pipe;
   logic [31:0] rdata_nxt;

   assign wd = avs_req.writedata;
   assign be = avs_req.byteenable;
   assign adr = avs_req.address;
   // access completes in the cycle where waitrequest is low
   assign wr_ack = avs_req.write & ~avs_waitrequest;
   assign rst_line = rst_busy_r | bus_reset_o; // se0 drive lasts until the pin drops
   assign sel_pipe = owner_r ? flow_pipe_r : cpu_pipe_r;
   // attach means lines not both low, with bus power on; own reset drive masked
   assign connected = vbus_r & ~rst_line & (line_i.dp | line_i.dm);
   assign rst_done = rst_busy_r & (rst_cnt_r == RESET_LAST);

   // one wait cycle then a single ready cycle per request
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         avs_waitrequest <= 1'b1;
      end else begin
         avs_waitrequest <= ~((avs_req.read | avs_req.write) & avs_waitrequest);
      end
   end

   // read mux, prepared while waitrequest is high
   always_comb begin
      rdata_nxt = uhc_pkg::RDATA_ZERO;
      case (adr)
         uhc_pkg::ADDR_CTRL: begin
            rdata_nxt[uhc_pkg::C_USB_EN] = usb_en_r;
            rdata_nxt[uhc_pkg::C_HOST_SEL] = host_sel_r;
            rdata_nxt[uhc_pkg::C_DETACH] = detach_r;
            rdata_nxt[uhc_pkg::C_BUS_RST] = rst_busy_r;
            rdata_nxt[uhc_pkg::C_SOF_EN] = sof_en_r;
            rdata_nxt[uhc_pkg::C_RESUME] = resume_r;
            rdata_nxt[uhc_pkg::C_VBUS_EN] = vbus_r;
         end
         uhc_pkg::ADDR_STAT: begin
            rdata_nxt[uhc_pkg::S_STATE_LO +: 2] = state_r;
            rdata_nxt[uhc_pkg::S_CONN] = connected;
            rdata_nxt[uhc_pkg::S_RST_SENT] = rst_sent_r;
            rdata_nxt[uhc_pkg::S_WAKEUP] = wakeup_r;
            rdata_nxt[uhc_pkg::S_UP_RSM] = up_rsm_r;
         end
         uhc_pkg::ADDR_IEN: begin
            rdata_nxt[uhc_pkg::S_RST_SENT] = rst_ien_r;
            rdata_nxt[uhc_pkg::S_WAKEUP] = wake_ien_r;
            rdata_nxt[uhc_pkg::S_UP_RSM] = rsm_ien_r;
         end
         uhc_pkg::ADDR_PSEL: begin
            rdata_nxt[uhc_pkg::P_NUM_LO +: PNW] = sel_pipe;
            rdata_nxt[uhc_pkg::P_OWNER] = owner_r;
            rdata_nxt[uhc_pkg::P_FLOW_RDY] = flow_rdy_r;
         end
         uhc_pkg::ADDR_PCFG: begin
            if (32'(cpu_pipe_r) < NPIPE) begin
               rdata_nxt[uhc_pkg::F_EN] = pipe_r[cpu_pipe_r].enable;
               rdata_nxt[uhc_pkg::F_ACT] = pipe_r[cpu_pipe_r].activate;
               rdata_nxt[uhc_pkg::F_TYPE_LO +: 2] = pipe_r[cpu_pipe_r].ptype;
               rdata_nxt[uhc_pkg::F_TOK_LO +: 2] = pipe_r[cpu_pipe_r].token;
               rdata_nxt[uhc_pkg::F_BANK_LO +: 2] = pipe_r[cpu_pipe_r].banks;
               rdata_nxt[uhc_pkg::F_SIZE_LO +: 3] = pipe_r[cpu_pipe_r].size;
               rdata_nxt[uhc_pkg::F_INTV_LO +: 8] = pipe_r[cpu_pipe_r].interval;
               rdata_nxt[uhc_pkg::F_VALID] = pipe_r[cpu_pipe_r].valid;
            end
         end
         uhc_pkg::ADDR_TADDR: begin
            rdata_nxt[6:0] = taddr_r;
         end
         default: begin
            rdata_nxt = uhc_pkg::RDATA_ZERO;
         end
      endcase
   end

   // read data register, stands through the ready cycle
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         avs_readdata <= uhc_pkg::RDATA_ZERO;
      end else if (avs_req.read & avs_waitrequest) begin
         avs_readdata <= rdata_nxt;
      end else begin
         avs_readdata <= uhc_pkg::RDATA_ZERO;
      end
   end

   // control bits written by firmware
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         usb_en_r <= 1'b0;
         host_sel_r <= 1'b0;
         detach_r <= uhc_pkg::CTRL_DETACH_RST;
         resume_r <= 1'b0;
         vbus_r <= 1'b0;
      end else if (wr_ack && adr == uhc_pkg::ADDR_CTRL && be[0]) begin
         usb_en_r <= wd[uhc_pkg::C_USB_EN];
         host_sel_r <= wd[uhc_pkg::C_HOST_SEL];
         detach_r <= wd[uhc_pkg::C_DETACH];
         resume_r <= wd[uhc_pkg::C_RESUME];
         vbus_r <= wd[uhc_pkg::C_VBUS_EN];
      end
   end

   // frame generation enable, also set by hardware after reset or resume
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         sof_en_r <= 1'b0;
      end else if (rst_done && !sof_en_r) begin
         sof_en_r <= 1'b1;
      end else if (resume_r && wr_ack && adr == uhc_pkg::ADDR_CTRL && be[0]
                   && !wd[uhc_pkg::C_RESUME]) begin
         sof_en_r <= 1'b1;
      end else if (wr_ack && adr == uhc_pkg::ADDR_CTRL && be[0]) begin
         sof_en_r <= wd[uhc_pkg::C_SOF_EN];
      end
   end

   // bus reset sequencer, one reset time of se0 drive
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_busy_r <= 1'b0;
         rst_cnt_r <= 24'h00_0000;
      end else if (rst_busy_r) begin
         rst_busy_r <= ~rst_done;
         rst_cnt_r <= rst_done ? 24'h00_0000 : rst_cnt_r + 24'h00_0001;
      end else if (wr_ack && adr == uhc_pkg::ADDR_CTRL && be[0] && wd[uhc_pkg::C_BUS_RST]
                   && state_r != uhc_pkg::HS_RESET) begin
         rst_busy_r <= 1'b1;
      end
   end

   // sticky status flags, set wins over clear, write zero clears
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sent_r <= 1'b0;
         wakeup_r <= 1'b0;
         up_rsm_r <= 1'b0;
      end else begin
         if (rst_done) begin
            rst_sent_r <= 1'b1;
         end else if (wr_ack && adr == uhc_pkg::ADDR_STAT && be[1]
                      && !wd[uhc_pkg::S_RST_SENT]) begin
            rst_sent_r <= 1'b0;
         end
         if ((rst_done && !sof_en_r)
             || (state_r == uhc_pkg::HS_SUSPEND && !(line_i.dp && !line_i.dm))) begin
            wakeup_r <= 1'b1;
         end else if (wr_ack && adr == uhc_pkg::ADDR_STAT && be[1]
                      && !wd[uhc_pkg::S_WAKEUP]) begin
            wakeup_r <= 1'b0;
         end
         if (state_r == uhc_pkg::HS_SUSPEND && !line_i.dp && line_i.dm) begin
            up_rsm_r <= 1'b1; // k state while suspended
         end else if (wr_ack && adr == uhc_pkg::ADDR_STAT && be[1]
                      && !wd[uhc_pkg::S_UP_RSM]) begin
            up_rsm_r <= 1'b0;
         end
      end
   end

   // interrupt enables, untouched by bus reset
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_ien_r <= 1'b0;
         wake_ien_r <= 1'b0;
         rsm_ien_r <= 1'b0;
      end else if (wr_ack && adr == uhc_pkg::ADDR_IEN && be[1]) begin
         rst_ien_r <= wd[uhc_pkg::S_RST_SENT];
         wake_ien_r <= wd[uhc_pkg::S_WAKEUP];
         rsm_ien_r <= wd[uhc_pkg::S_UP_RSM];
      end
   end

   // pipe selection registers, number goes to the one chosen by owner
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         owner_r <= 1'b0;
         flow_rdy_r <= 1'b0;
         cpu_pipe_r <= '0;
         flow_pipe_r <= '0;
      end else if (wr_ack && adr == uhc_pkg::ADDR_PSEL) begin
         if (be[0]) begin
            owner_r <= wd[uhc_pkg::P_OWNER];
            if (wd[uhc_pkg::P_OWNER]) begin
               flow_pipe_r <= wd[uhc_pkg::P_NUM_LO +: PNW];
            end else begin
               cpu_pipe_r <= wd[uhc_pkg::P_NUM_LO +: PNW];
            end
         end
         if (be[1]) begin
            flow_rdy_r <= wd[uhc_pkg::P_FLOW_RDY];
         end
      end
   end

   // target address, cleared when a bus reset has been sent
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         taddr_r <= uhc_pkg::ADDR_DEFAULT;
      end else if (rst_done) begin
         taddr_r <= uhc_pkg::ADDR_DEFAULT;
      end else if (wr_ack && adr == uhc_pkg::ADDR_TADDR && be[0]) begin
         taddr_r <= wd[6:0];
      end
   end

   // per pipe configuration storage
   generate
      for (genvar p = 0; p < NPIPE; p++) begin : g_pipe
         logic hit;
         logic ctrl_bad;
         assign hit = wr_ack && adr == uhc_pkg::ADDR_PCFG && be[0] && cpu_pipe_r == PNW'(p);
         assign ctrl_bad = wd[uhc_pkg::F_TYPE_LO +: 2] == uhc_pkg::TYPE_CTRL
                           && wd[uhc_pkg::F_BANK_LO +: 2] != uhc_pkg::BANK_ONE;
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               pipe_r[p] <= uhc_pkg::PIPE_CFG_RST;
            end else if (rst_done) begin
               pipe_r[p] <= uhc_pkg::PIPE_CFG_RST;
            end else if (hit && !wd[uhc_pkg::F_EN]) begin
               pipe_r[p] <= uhc_pkg::PIPE_CFG_RST;
            end else if (hit && pipe_r[p].valid) begin
               pipe_r[p].token <= wd[uhc_pkg::F_TOK_LO +: 2];
               pipe_r[p].activate <= wd[uhc_pkg::F_ACT];
               if (be[2]) begin
                  pipe_r[p].interval <= wd[uhc_pkg::F_INTV_LO +: 8];
               end
            end else if (hit) begin
               pipe_r[p].enable <= 1'b1;
               pipe_r[p].activate <= wd[uhc_pkg::F_ACT];
               pipe_r[p].ptype <= wd[uhc_pkg::F_TYPE_LO +: 2];
               pipe_r[p].token <= wd[uhc_pkg::F_TOK_LO +: 2];
               pipe_r[p].banks <= wd[uhc_pkg::F_BANK_LO +: 2];
               pipe_r[p].size <= be[1] ? wd[uhc_pkg::F_SIZE_LO +: 3] : pipe_r[p].size;
               pipe_r[p].interval <= be[2] ? wd[uhc_pkg::F_INTV_LO +: 8] : pipe_r[p].interval;
               pipe_r[p].valid <= ~ctrl_bad;
            end
         end
         // pipe may carry requests once enabled, valid, activated and host ready, with no bus reset running
         always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
               pipe_ready_o[p] <= 1'b0;
            end else begin
               pipe_ready_o[p] <= pipe_r[p].enable & pipe_r[p].activate & pipe_r[p].valid
                                  & (state_r == uhc_pkg::HS_READY) & ~rst_busy_r;
            end
         end
      end
   endgenerate

   // host state machine next state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         uhc_pkg::HS_RESET: begin
            if (usb_en_r && host_sel_r && !detach_r) begin
               state_nxt = uhc_pkg::HS_IDLE;
            end
         end
         uhc_pkg::HS_IDLE: begin
            if (connected) begin
               state_nxt = uhc_pkg::HS_READY;
            end
         end
         uhc_pkg::HS_READY: begin
            if (!connected && !rst_line) begin
               state_nxt = uhc_pkg::HS_IDLE;
            end else if (!sof_en_r && !rst_busy_r) begin
               state_nxt = uhc_pkg::HS_SUSPEND;
            end
         end
         uhc_pkg::HS_SUSPEND: begin
            if (!connected && !rst_line) begin
               state_nxt = uhc_pkg::HS_IDLE;
            end else if (sof_en_r) begin
               state_nxt = uhc_pkg::HS_READY;
            end
         end
         default: begin
            state_nxt = uhc_pkg::HS_RESET;
         end
      endcase
      if (!usb_en_r || !host_sel_r || detach_r) begin
         state_nxt = uhc_pkg::HS_RESET;
      end
   end

   // host state register
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= uhc_pkg::HS_RESET;
      end else begin
         state_r <= state_nxt;
      end
   end

   // registered pin and status outputs
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         vbus_en_o <= 1'b0;
         bus_reset_o <= 1'b0;
         resume_o <= 1'b0;
         sof_active_o <= 1'b0;
         host_irq_o <= 1'b0;
         dev_addr_o <= uhc_pkg::ADDR_DEFAULT;
         flow_pipe_o <= '0;
         flow_run_o <= 1'b0;
      end else begin
         vbus_en_o <= vbus_r;
         bus_reset_o <= rst_busy_r;
         resume_o <= resume_r & (state_r == uhc_pkg::HS_SUSPEND);
         sof_active_o <= sof_en_r & (state_r == uhc_pkg::HS_READY) & ~rst_busy_r;
         host_irq_o <= (rst_sent_r & rst_ien_r) | (wakeup_r & wake_ien_r)
                       | (up_rsm_r & rsm_ien_r);
         dev_addr_o <= taddr_r;
         flow_pipe_o <= flow_pipe_r;
         flow_run_o <= flow_rdy_r & (state_r == uhc_pkg::HS_READY);
      end
   end
endmodule

// ---- uhc_pkg.sv ----
// package of constants and types for the usb host pipe and bus control block
package uhc_pkg;
   // register byte offsets
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_IEN = 8'h08;
   localparam logic [7:0] ADDR_PSEL = 8'h0C;
   localparam logic [7:0] ADDR_PCFG = 8'h10;
   localparam logic [7:0] ADDR_TADDR = 8'h14;
   // control register bits
   localparam int C_USB_EN = 0;
   localparam int C_HOST_SEL = 1;
   localparam int C_DETACH = 2;
   localparam int C_BUS_RST = 3;
   localparam int C_SOF_EN = 4;
   localparam int C_RESUME = 5;
   localparam int C_VBUS_EN = 6;
   // status register bits
   localparam int S_STATE_LO = 0;
   localparam int S_CONN = 4;
   localparam int S_RST_SENT = 8;
   localparam int S_WAKEUP = 9;
   localparam int S_UP_RSM = 10;
   // pipe select register bits
   localparam int P_NUM_LO = 0;
   localparam int P_OWNER = 4;
   localparam int P_FLOW_RDY = 8;
   // pipe config register bits
   localparam int F_EN = 0;
   localparam int F_ACT = 1;
   localparam int F_TYPE_LO = 2;
   localparam int F_TOK_LO = 4;
   localparam int F_BANK_LO = 6;
   localparam int F_SIZE_LO = 8;
   localparam int F_INTV_LO = 16;
   localparam int F_VALID = 31;
   // encodings and reset values
   localparam logic [1:0] TYPE_CTRL = 2'h0;
   localparam logic [1:0] BANK_ONE = 2'h0;
   localparam logic CTRL_DETACH_RST = 1'b1;
   localparam logic [6:0] ADDR_DEFAULT = 7'h00;
   localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;
   localparam int CLK_PERIOD_NS = 4;
   localparam int BUS_RESET_NS = 10_000_000;
   // host controller states, gray along reset-idle-ready-suspend
   typedef enum logic [1:0] {
      HS_RESET = 2'h0,
      HS_IDLE = 2'h1,
      HS_READY = 2'h3,
      HS_SUSPEND = 2'h2
   } uhc_hstate_t;
   // usb line levels
   typedef struct packed {
      logic dp;
      logic dm;
   } uhc_line_t;
   // avalon request group
   typedef struct packed {
      logic [7:0] address;
      logic read;
      logic write;
      logic [31:0] writedata;
      logic [3:0] byteenable;
   } uhc_avm_req_t;
   // one pipe's configuration
   typedef struct packed {
      logic enable;
      logic activate;
      logic [1:0] ptype;
      logic [1:0] token;
      logic [1:0] banks;
      logic [2:0] size;
      logic [7:0] interval;
      logic valid;
   } uhc_pipe_cfg_t;
   localparam uhc_pipe_cfg_t PIPE_CFG_RST = '0;
endpackage

// ---- uhc_host_ctrl_asserts.sv ----
// assertion checker for the usb host control block, bound to its ports
`timescale 1ns/100ps
module uhc_host_ctrl_asserts #(
   parameter int NPIPE = 7,
   parameter int PNW = 3,
   parameter int BUS_RESET_NS = 400
) (
   input wire logic ref_clk,
   input wire logic arst_n,
   input wire uhc_pkg::uhc_avm_req_t avs_req,
   input wire logic [31:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic vbus_en_o,
   input wire logic bus_reset_o,
   input wire logic resume_o,
   input wire logic sof_active_o,
   input wire logic [6:0] dev_addr_o,
   input wire logic flow_run_o,
   input wire logic [NPIPE-1:0] pipe_ready_o
);
   localparam int RESET_CYC = BUS_RESET_NS / uhc_pkg::CLK_PERIOD_NS;
   logic wr_done;
   logic ctrl_wr;
   logic brst_cmd;
   logic psel_clr;
   logic taddr_wr;
   logic [31:0] wd_r;
   int brst_cnt_r;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!arst_n);
   // writes completing at this edge, by target
   assign wr_done = avs_req.write & ~avs_waitrequest;
   assign ctrl_wr = wr_done & avs_req.byteenable[0] & (avs_req.address == 8'h00);
   assign brst_cmd = ctrl_wr & avs_req.writedata[3];
   assign psel_clr = wr_done & avs_req.byteenable[1] & (avs_req.address == 8'h0C) &
      ~avs_req.writedata[8];
   assign taddr_wr = wr_done & avs_req.byteenable[0] & (avs_req.address == 8'h14);
   // last written word and length of the running bus reset
   always_ff @(posedge ref_clk or negedge arst_n) begin
      if (!arst_n) begin
         wd_r <= 32'h0000_0000;
         brst_cnt_r <= 0;
      end else begin
         wd_r <= wr_done ? avs_req.writedata : wd_r;
         brst_cnt_r <= bus_reset_o ? brst_cnt_r + 1 : 0;
      end
   end
   sequence s_req_wait;
      (avs_req.read || avs_req.write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest;
   endsequence
   sequence s_brst_end;
      bus_reset_o ##1 !bus_reset_o;
   endsequence
   a_one_wait: assert property (s_req_wait |=> s_answer)
      else $error("request not answered after one wait cycle");
   a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_rdata_zero: assert property (avs_waitrequest |-> avs_readdata == 32'h0000_0000)
      else $error("read data not zero outside an answer");
   a_vbus_copy: assert property (ctrl_wr |-> ##2 vbus_en_o == wd_r[6])
      else $error("bus power does not follow its control bit");
   a_brst_start: assert property ($rose(bus_reset_o) |->
      $past(brst_cmd) || $past(brst_cmd, 2) || $past(brst_cmd, 3))
      else $error("bus reset without a command");
   a_brst_len: assert property (s_brst_end |-> brst_cnt_r == RESET_CYC)
      else $error("bus reset length wrong");
   a_brst_clear: assert property (s_brst_end |-> ##2
      dev_addr_o == 7'h00 && pipe_ready_o == '0)
      else $error("address or pipes kept after bus reset");
   a_sof_excl: assert property (sof_active_o |-> !resume_o)
      else $error("frames and resume together");
   a_flow_freeze: assert property (psel_clr |-> ##2 !flow_run_o)
      else $error("flow not frozen");
   a_taddr_load: assert property (taddr_wr |-> ##2 dev_addr_o == wd_r[6:0])
      else $error("target address not loaded");
endmodule
bind uhc_host_ctrl uhc_host_ctrl_asserts #(.NPIPE(NPIPE), .PNW(PNW),
   .BUS_RESET_NS(BUS_RESET_NS)) u_chk (.ref_clk(ref_clk), .arst_n(arst_n),
   .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
   .vbus_en_o(vbus_en_o), .bus_reset_o(bus_reset_o), .resume_o(resume_o),
   .sof_active_o(sof_active_o), .dev_addr_o(dev_addr_o), .flow_run_o(flow_run_o),
   .pipe_ready_o(pipe_ready_o));

// ---- uhc_dev_model.sv ----
// behavioural model of the attached usb device as seen on the bus lines
`timescale 1ns/100ps
module uhc_dev_model (
   input wire logic vbus,
   input wire logic attach,
   input wire logic send_k,
   input wire logic bus_reset,
   output uhc_pkg::uhc_line_t line_o
);
   // host pull-downs win unless powered and plugged; host drives se0 in bus reset
   always_comb begin
      if (!vbus || !attach || bus_reset) begin
         line_o = '{dp: 1'b0, dm: 1'b0};
      end else if (send_k) begin
         line_o = '{dp: 1'b0, dm: 1'b1};
      end else begin
         line_o = '{dp: 1'b1, dm: 1'b0};
      end
   end
endmodule

// ---- uhc_host_ctrl_tb.sv ----
// self-checking bench for the usb host control block
`timescale 1ns/100ps
module uhc_host_ctrl_tb;
   logic ref_clk = 1'b0;
   logic arst_n = 1'b0;
   uhc_pkg::uhc_avm_req_t avs_req = '0;
   logic [31:0] avs_readdata;
   logic avs_waitrequest;
   uhc_pkg::uhc_line_t line_i;
   logic vbus_en_o, bus_reset_o, resume_o, sof_active_o, host_irq_o, flow_run_o;
   logic [6:0] dev_addr_o;
   logic [2:0] flow_pipe_o;
   logic [6:0] pipe_ready_o;
   logic attach = 1'b0;
   logic send_k = 1'b0;
   logic [31:0] exp_q[$];
   logic [31:0] r1;
   logic [31:0] r2;
   int miscompares = 0;
   int checks = 0;
   int cyc = 0;
   int seed = 32'ha59b_d5cc;
   always #2 ref_clk = ~ref_clk;
   uhc_host_ctrl #(.BUS_RESET_NS(400)) u_dut (.ref_clk(ref_clk), .arst_n(arst_n),
      .avs_req(avs_req), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .line_i(line_i), .vbus_en_o(vbus_en_o), .bus_reset_o(bus_reset_o),
      .resume_o(resume_o), .sof_active_o(sof_active_o), .host_irq_o(host_irq_o),
      .dev_addr_o(dev_addr_o), .flow_pipe_o(flow_pipe_o), .flow_run_o(flow_run_o),
      .pipe_ready_o(pipe_ready_o));
   uhc_dev_model u_dev (.vbus(vbus_en_o), .attach(attach), .send_k(send_k),
      .bus_reset(bus_reset_o), .line_o(line_i));
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic end_sim();
      if (miscompares == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // one avalon access, held until waitrequest is sampled low
   task automatic acc(input logic [7:0] a, input logic rd, input logic [31:0] d);
      avs_req.address <= a;
      avs_req.read <= rd;
      avs_req.write <= !rd;
      avs_req.writedata <= d;
      avs_req.byteenable <= 4'hF;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_req.read <= 1'b0;
      avs_req.write <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      acc(a, 1'b0, d);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      acc(a, 1'b1, 32'h0000_0000);
   endtask
   task automatic brst();
      wait (bus_reset_o === 1'b1);
      wait (bus_reset_o === 1'b0);
      repeat (8) @(posedge ref_clk);
   endtask
   // read data checked against the oldest expectation when the answer stands
   always @(posedge ref_clk) begin
      if (avs_req.read && avs_waitrequest === 1'b0) begin
         chk("readdata", exp_q.pop_front(), avs_readdata);
      end
   end
   // hang guard
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         end_sim();
      end
   end
   // main sequence
   initial begin
      repeat (8) @(posedge ref_clk);
      arst_n <= 1'b1;
      @(posedge ref_clk);
      rd(8'h00, 32'h0000_0004);
      rd(8'h04, 32'h0000_0000);
      wr(8'h20, 32'hFFFF_FFFF);
      rd(8'h20, 32'h0000_0000);
      wr(8'h00, 32'h0000_0047);
      rd(8'h04, 32'h0000_0000);
      wr(8'h00, 32'h0000_0053);
      rd(8'h04, 32'h0000_0001);
      attach <= 1'b1;
      repeat (6) @(posedge ref_clk);
      rd(8'h04, 32'h0000_0013);
      chk("sof", 32'h1, {31'h0, sof_active_o});
      r1 = {25'h0, 7'($random(seed))};
      wr(8'h14, r1);
      rd(8'h14, r1);
      chk("dev_addr", r1, {25'h0, dev_addr_o});
      wr(8'h0C, 32'h0000_0115);
      chk("flow_run", 32'h1, {31'h0, flow_run_o});
      wr(8'h0C, 32'h0000_0002);
      chk("flow_run", 32'h0, {31'h0, flow_run_o});
      rd(8'h0C, 32'h0000_0002);
      wr(8'h0C, 32'h0000_0102);
      chk("flow_run", 32'h1, {31'h0, flow_run_o});
      chk("flow_pipe", 32'h5, {29'h0, flow_pipe_o});
      wr(8'h10, 32'h0000_0043);
      rd(8'h10, 32'h0000_0043);
      wr(8'h10, 32'h0000_0000);
      rd(8'h10, 32'h0000_0000);
      r1 = {8'h00, 8'($random(seed)), 5'h00, 3'($random(seed)), 8'h03};
      wr(8'h10, r1);
      rd(8'h10, r1 | 32'h8000_0000);
      chk("pipe_ready", 32'h4, {25'h0, pipe_ready_o});
      r2 = {8'h00, 8'($random(seed)), r1[15:0] | 16'h0024};
      wr(8'h10, r2);
      rd(8'h10, {8'h80, r2[23:16], r1[15:0] | 16'h0020});
      wr(8'h08, 32'h0000_0100);
      wr(8'h00, 32'h0000_005B);
      brst();
      chk("dev_addr", 32'h0, {25'h0, dev_addr_o});
      chk("irq", 32'h1, {31'h0, host_irq_o});
      rd(8'h04, 32'h0000_0113);
      rd(8'h08, 32'h0000_0100);
      rd(8'h10, 32'h0000_0000);
      wr(8'h04, 32'hFFFF_FFFF);
      rd(8'h04, 32'h0000_0113);
      wr(8'h04, 32'h0000_0000);
      rd(8'h04, 32'h0000_0013);
      wr(8'h00, 32'h0000_0043);
      chk("sof", 32'h0, {31'h0, sof_active_o});
      rd(8'h04, 32'h0000_0012);
      wr(8'h00, 32'h0000_004B);
      brst();
      rd(8'h00, 32'h0000_0053);
      rd(8'h04, 32'h0000_0313);
      wr(8'h04, 32'h0000_0000);
      wr(8'h00, 32'h0000_0043);
      send_k <= 1'b1;
      repeat (4) @(posedge ref_clk);
      send_k <= 1'b0;
      rd(8'h04, 32'h0000_0612);
      wr(8'h00, 32'h0000_0063);
      chk("resume", 32'h1, {31'h0, resume_o});
      wr(8'h00, 32'h0000_0043);
      rd(8'h00, 32'h0000_0053);
      chk("sof", 32'h1, {31'h0, sof_active_o});
      attach <= 1'b0;
      repeat (6) @(posedge ref_clk);
      rd(8'h04, 32'h0000_0601);
      end_sim();
   end
endmodule
